// ### src/low_power_idle_regs.vh
`ifndef LOW_POWER_IDLE_REGS_VH
`define LOW_POWER_IDLE_REGS_VH

// register addresses on the management register port
`define LPI_CAPABILITY_ADDR 16'h8000
`define LPI_ADVERTISEMENT_ADDR 16'h8001

// field positions shared by both registers
`define LPI_BIT_BACKPLANE_KR 6
`define LPI_BIT_BACKPLANE_KX4 5
`define LPI_BIT_BACKPLANE_KX_GIG 4
`define LPI_BIT_TENGIG_COPPER 3
`define LPI_BIT_GIG_COPPER 2
`define LPI_BIT_FAST_COPPER 1

// fixed capability value and the two advertisement reset values
`define LPI_CAPABILITY_VALUE 16'h0006
`define LPI_ADV_RESET_ENABLED 16'h0006
`define LPI_ADV_RESET_DISABLED 16'h0000

`endif

// ### src/low_power_idle_reg_bank.v

`include "low_power_idle_regs.vh"

module low_power_idle_reg_bank (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // hardware configuration strap pin
  input wire lpi_strap_enable_in,
  // decoded management register access
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [15:0] reg_rdata_out,
  output reg reg_rvalid_out,
  // offers towards autonegotiation
  output wire adv_gig_copper_out,
  output wire adv_fast_copper_out
);

  // header values as sized constants, so that single bits can be
  // picked out of them without shifting a 16-bit value into one bit
  localparam [15:0] cap_value = `LPI_CAPABILITY_VALUE;
  localparam [15:0] adv_reset_on = `LPI_ADV_RESET_ENABLED;
  localparam [15:0] adv_reset_off = `LPI_ADV_RESET_DISABLED;
  localparam [15:0] cap_addr = `LPI_CAPABILITY_ADDR;
  localparam [15:0] adv_addr = `LPI_ADVERTISEMENT_ADDR;

  // strap synchroniser flops
  reg strap_meta;
  reg strap_sync;

  // stored advertisement bits, the only state of the bank that a write can change
  reg adv_gig_copper;
  reg adv_fast_copper;

  // next values of the stored bits
  reg next_adv_gig_copper;
  reg next_adv_fast_copper;

  // next values of the read answer
  reg [15:0] next_rdata;
  reg next_rvalid;

  // address decode results
  wire cap_selected;
  wire adv_selected;
  wire adv_write;

  // capability fields, all fixed
  wire cap_backplane_kr;
  wire cap_backplane_kx4;
  wire cap_backplane_kx_gig;
  wire cap_tengig_copper;
  wire cap_gig_copper;
  wire cap_fast_copper;

  // read-only advertisement fields, all fixed at zero
  wire adv_backplane_kr;
  wire adv_backplane_kx4;
  wire adv_backplane_kx_gig;
  wire adv_tengig_copper;

  // assembled register words as seen by a read
  wire [15:0] capability_word;
  wire [15:0] advertisement_word;

  // reset values of the two writable bits, picked by the strap
  wire gig_reset_value;
  wire fast_reset_value;

  // strap comes from a pin: two flops, left free-running so the
  // synchronised level is valid while reset is still held; only the
  // second flop is read, the first may be metastable
  always @(posedge clk_in) begin
    strap_meta <= lpi_strap_enable_in;
    strap_sync <= strap_meta;
  end

  // address decode; a full 16-bit compare, so aliases never hit
  assign cap_selected = (reg_addr_in == cap_addr);
  assign adv_selected = (reg_addr_in == adv_addr);

  // a write to the capability address decodes to nothing at all,
  // which is how its read-only bits stay untouched
  assign adv_write = reg_write_in & adv_selected;

  // capability fields straight from the fixed value
  assign cap_backplane_kr = cap_value[`LPI_BIT_BACKPLANE_KR];
  assign cap_backplane_kx4 = cap_value[`LPI_BIT_BACKPLANE_KX4];
  assign cap_backplane_kx_gig = cap_value[`LPI_BIT_BACKPLANE_KX_GIG];
  assign cap_tengig_copper = cap_value[`LPI_BIT_TENGIG_COPPER];
  assign cap_gig_copper = cap_value[`LPI_BIT_GIG_COPPER];
  assign cap_fast_copper = cap_value[`LPI_BIT_FAST_COPPER];

  // capability word; reserved bits are tied low here, not taken from
  // the constant, so a wrong header value cannot leak into them
  assign capability_word = {9'h000,
                            cap_backplane_kr,
                            cap_backplane_kx4,
                            cap_backplane_kx_gig,
                            cap_tengig_copper,
                            cap_gig_copper,
                            cap_fast_copper,
                            1'h0};

  // read-only advertisement fields; no flop behind them, so a write
  // has nothing to land in
  assign adv_backplane_kr = 1'h0;
  assign adv_backplane_kx4 = 1'h0;
  assign adv_backplane_kx_gig = 1'h0;
  assign adv_tengig_copper = 1'h0;

  // advertisement word; only the two copper bits carry state
  assign advertisement_word = {9'h000,
                               adv_backplane_kr,
                               adv_backplane_kx4,
                               adv_backplane_kx_gig,
                               adv_tengig_copper,
                               adv_gig_copper,
                               adv_fast_copper,
                               1'h0};

  // reset values follow the synchronised strap; the strap must be
  // steady for two edges before the last reset edge to be seen
  assign gig_reset_value = strap_sync ?
                           adv_reset_on[`LPI_BIT_GIG_COPPER] :
                           adv_reset_off[`LPI_BIT_GIG_COPPER];
  assign fast_reset_value = strap_sync ?
                            adv_reset_on[`LPI_BIT_FAST_COPPER] :
                            adv_reset_off[`LPI_BIT_FAST_COPPER];

  // next value of the writable bits; reset wins over a write in the
  // same cycle, other bits of the written word are dropped on purpose
  always @* begin
    next_adv_gig_copper = adv_gig_copper;
    next_adv_fast_copper = adv_fast_copper;
    if (!rst_n_in) begin
      next_adv_gig_copper = gig_reset_value;
      next_adv_fast_copper = fast_reset_value;
    end else if (adv_write) begin
      next_adv_gig_copper = reg_wdata_in[`LPI_BIT_GIG_COPPER];
      next_adv_fast_copper = reg_wdata_in[`LPI_BIT_FAST_COPPER];
    end
  end

  // advertisement flops
  always @(posedge clk_in) begin
    adv_gig_copper <= next_adv_gig_copper;
    adv_fast_copper <= next_adv_fast_copper;
  end

  // read answer; data holds between reads, unmapped addresses read
  // zero; a read in the same cycle as a write sees the old value
  always @* begin
    next_rvalid = 1'h0;
    next_rdata = reg_rdata_out;
    if (!rst_n_in) begin
      next_rdata = 16'h0000;
    end else if (reg_read_in) begin
      next_rvalid = 1'h1;
      if (cap_selected) begin
        next_rdata = capability_word;
      end else if (adv_selected) begin
        next_rdata = advertisement_word;
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  // registered read answer, one cycle after the request; rvalid is
  // a single-cycle pulse, the data stands until the next read
  always @(posedge clk_in) begin
    reg_rdata_out <= next_rdata;
    reg_rvalid_out <= next_rvalid;
  end

  // offers go straight from the stored bits, so autonegotiation sees
  // a write on the cycle after it is taken
  assign adv_gig_copper_out = adv_gig_copper;
  assign adv_fast_copper_out = adv_fast_copper;

  // limitation: the strap is read only through reset; changing the
  // pin later has no effect until the next reset

endmodule // low_power_idle_reg_bank

// ### verification/lpi_chk_assertions.sv
module lpi_chk(input wire clk_in, rst_n_in, lpi_strap_enable_in, reg_write_in,
  reg_read_in, reg_rvalid_out, adv_gig_copper_out, adv_fast_copper_out,
  input wire [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  rvalid_pulse_a: assert property (reg_rvalid_out == $past(reg_read_in))
    else $error("rvalid not one cycle after read");
  cap_value_a: assert property (reg_read_in && reg_addr_in == 16'h8000
    |=> reg_rdata_out == 16'h0006) else $error("capability value");
  rsvd_zero_a: assert property (reg_rvalid_out
    |-> !reg_rdata_out[15:3] && !reg_rdata_out[0]) else $error("reserved set");
  adv_read_a: assert property (reg_read_in && reg_addr_in == 16'h8001
    |=> reg_rdata_out[2:1] == {$past(adv_gig_copper_out),
    $past(adv_fast_copper_out)}) else $error("adv readback");
  adv_write_a: assert property (reg_write_in && reg_addr_in == 16'h8001
    |=> {adv_gig_copper_out, adv_fast_copper_out} == $past(reg_wdata_in[2:1]))
    else $error("adv write");
  adv_hold_a: assert property (!(reg_write_in && reg_addr_in == 16'h8001)
    |=> $stable(adv_gig_copper_out) && $stable(adv_fast_copper_out))
    else $error("adv changed without write");
  adv_reset_a: assert property ($rose(rst_n_in) |-> adv_gig_copper_out ==
    lpi_strap_enable_in && adv_fast_copper_out == lpi_strap_enable_in)
    else $error("adv reset value");
  cover property (reg_write_in && reg_addr_in == 16'h8001);
  cover property (reg_read_in && reg_addr_in == 16'h8000);
  cover property ($rose(rst_n_in) && !lpi_strap_enable_in);
endmodule // lpi_chk
bind low_power_idle_reg_bank lpi_chk chk(.clk_in, .rst_n_in, .reg_read_in,
  .lpi_strap_enable_in, .reg_write_in, .reg_rvalid_out, .adv_gig_copper_out,
  .adv_fast_copper_out, .reg_addr_in, .reg_wdata_in, .reg_rdata_out);

// ### verification/mgmt_sw.sv
module mgmt_sw(input wire clk_in, input wire [15:0] rdata_in,
  input wire rvalid_in, output logic [15:0] addr_out = 0,
  output logic [15:0] wdata_out = 0, output logic wr_out = 0,
  output logic rd_out = 0);
  timeunit 1ns; timeprecision 1ns;
  // one strobe per access, driven just after an edge so two calls never
  // touch a line twice in one time step; released lines show inverted data
  task xfer(input w, input [15:0] a, d, output [15:0] q);
    @(posedge clk_in) #1 {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(posedge clk_in) #1 {wr_out, rd_out, addr_out, wdata_out} = {2'b0, ~a, ~d};
    q = rvalid_in ? rdata_in : 16'hxxxx;
  endtask
endmodule // mgmt_sw

// ### verification/test_energy_efficient_cap_adv_regs.sv
module test_energy_efficient_cap_adv_regs;
  timeunit 1ns; timeprecision 1ns;
  logic clk_in = 0, rst_n_in = 0, s = 1;
  logic [15:0] q;
  int n_fail = 0, checks = 0;
  wire [15:0] a, d, r;
  wire w, rd, v, g, f;
  mgmt_sw sw(.clk_in, .rdata_in(r), .rvalid_in(v), .addr_out(a),
    .wdata_out(d), .wr_out(w), .rd_out(rd));
  low_power_idle_reg_bank dut(.clk_in, .rst_n_in, .lpi_strap_enable_in(s),
    .reg_addr_in(a), .reg_wdata_in(d), .reg_write_in(w), .reg_read_in(rd),
    .reg_rdata_out(r), .reg_rvalid_out(v), .adv_gig_copper_out(g),
    .adv_fast_copper_out(f));
  initial forever #25 clk_in = ~clk_in;
  task cmp(input [15:0] got, e);
    checks++;
    if (got !== e) begin
      n_fail++;
      $display("mismatch %0t got %h want %h", $time, got, e);
    end
  endtask
  // a write is judged by the offer outputs, a read by its data
  task rw(input x, input [15:0] ad, dt, e);
    sw.xfer(x, ad, dt, q);
    cmp(x ? {14'h0, g, f} : q, e);
  endtask
  task t_reset(input st, input [15:0] e);
    s = st;
    rst_n_in = 0;
    repeat (10) @(posedge clk_in);
    #1 rst_n_in = 1;
    rw(0, 16'h8001, 0, e);
  endtask
  task t_cap;
    rw(0, 16'h8000, 0, 16'h0006);
    rw(1, 16'h8000, 16'hffff, 16'h0003);
    rw(0, 16'h8000, 0, 16'h0006);
    rw(0, 16'h8002, 0, 16'h0000);
  endtask
  task t_adv;
    rw(1, 16'h8001, 16'hfffd, 16'h0002);
    rw(0, 16'h8001, 0, 16'h0004);
    rw(1, 16'h8001, 16'h0002, 16'h0001);
    rw(0, 16'h8001, 0, 16'h0002);
  endtask
  task report_and_stop;
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    t_reset(1, 16'h0006);
    t_cap;
    t_adv;
    t_reset(0, 16'h0000);
    report_and_stop;
  end
  // whole run is about forty cycles
  initial begin
    #20000 n_fail++;
    report_and_stop;
  end
endmodule // test_energy_efficient_cap_adv_regs
